//--- hdl/lmi_i2c_slave.sv

`default_nettype none

// Dual clock queue with gray coded pointers
module lmi_async_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic             w_clk,
	input  wire logic             w_rst_n,
	input  wire logic             w_valid,
	output logic                  w_ready,
	input  wire logic [WIDTH-1:0] w_data,
	input  wire logic             r_clk,
	input  wire logic             r_rst_n,
	output logic                  r_valid,
	input  wire logic             r_ready,
	output logic      [WIDTH-1:0] r_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wbin_q;
	logic [AW:0]      wgray_q;
	logic [AW:0]      rbin_q;
	logic [AW:0]      rgray_q;
	logic [AW:0]      rgray_s1;
	logic [AW:0]      rgray_s2;
	logic [AW:0]      wgray_s1;
	logic [AW:0]      wgray_s2;
	logic [AW:0]      wbin_d;
	logic [AW:0]      rbin_d;

	function automatic logic [AW:0] to_gray(input logic [AW:0] b);
		return b ^ (b >> 1);
	endfunction

	assign wbin_d  = wbin_q + 1'b1;
	assign rbin_d  = rbin_q + 1'b1;
	// Full when the write pointer is one lap ahead of the read pointer
	assign w_ready = (wgray_q != {~rgray_s2[AW:AW-1], rgray_s2[AW-2:0]});
	assign r_valid = (rgray_q != wgray_s2);
	assign r_data  = mem[rbin_q[AW-1:0]];

	// Storage has no reset; only slots behind the write pointer are ever read
	always_ff @(posedge w_clk) begin
		if (w_valid && w_ready) begin
			mem[wbin_q[AW-1:0]] <= w_data;
		end
	end

	// Write pointer
	always_ff @(posedge w_clk) begin
		if (!w_rst_n) begin
			wbin_q  <= '0;
			wgray_q <= '0;
		end else if (w_valid && w_ready) begin
			wbin_q  <= wbin_d;
			wgray_q <= to_gray(wbin_d);
		end
	end

	// Read pointer
	always_ff @(posedge r_clk) begin
		if (!r_rst_n) begin
			rbin_q  <= '0;
			rgray_q <= '0;
		end else if (r_valid && r_ready) begin
			rbin_q  <= rbin_d;
			rgray_q <= to_gray(rbin_d);
		end
	end

	// Pointer synchronisers
	always_ff @(posedge w_clk) begin
		rgray_s1 <= rgray_q;
		rgray_s2 <= rgray_s1;
	end

	always_ff @(posedge r_clk) begin
		wgray_s1 <= wgray_q;
		wgray_s2 <= wgray_s1;
	end
endmodule

// Serial slave port giving a master access to the control registers
module lmi_i2c_slave #(
	parameter logic [6:0] SLAVE_ADDR = lmi_pkg::DEV_ADDR,
	parameter int         FIFO_DEPTH = lmi_pkg::FIFO_DEPTH
) (
	input  wire logic                     CORE_CLK,
	input  wire logic                     RST_N,
	input  wire logic                     LINK_CLK,
	input  wire logic                     SCL_I,
	input  wire logic                     SDA_I,
	output logic                          SDA_O,
	output logic                          SDA_OE_N,
	output logic                          WR_VALID,
	input  wire logic                     WR_READY,
	output logic [lmi_pkg::IDX_W-1:0]     WR_INDEX,
	output logic [lmi_pkg::DAT_W-1:0]     WR_DATA,
	output logic [lmi_pkg::IDX_W-1:0]     RD_INDEX,
	input  wire logic [lmi_pkg::DAT_W-1:0] RD_DATA
);
	import lmi_pkg::*;

	logic              lrst_s1;
	logic              link_rst_n;
	logic              scl_s1;
	logic              scl_s2;
	logic              scl_s3;
	logic              sda_s1;
	logic              sda_s2;
	logic              sda_s3;
	logic              scl_rise;
	logic              scl_fall;
	logic              start_c;
	logic              stop_c;
	lmi_state_t        state_q;
	lmi_kind_t         kind_q;
	logic [3:0]        cnt_q;
	logic [7:0]        shreg_q;
	logic [7:0]        tx_q;
	logic [IDX_W-1:0]  index_q;
	logic              rw_q;
	logic              drive_q;
	logic              nak_q;
	logic              byte_done;
	logic              addr_hit;
	logic              ack_d;
	logic              push;
	logic              fifo_w_ready;
	logic [WORD_W-1:0] fifo_r_data;
	logic              rd_req_q;
	logic              rack_s1;
	logic              rack_s2;
	logic              rack_s3;
	logic [DAT_W-1:0]  rd_byte_q;
	logic              rreq_s1;
	logic              rreq_s2;
	logic              rreq_s3;
	logic              fetch_q;
	logic              rd_ack_q;
	logic [IDX_W-1:0]  rd_index_q;
	logic [DAT_W-1:0]  rd_data_q;

	// Open-drain line: only ever pulled low
	assign SDA_O    = 1'b0;
	assign SDA_OE_N = ~drive_q;
	assign RD_INDEX = rd_index_q;
	assign WR_INDEX = fifo_r_data[WORD_W-1:DAT_W];
	assign WR_DATA  = fifo_r_data[DAT_W-1:0];

	// Core reset carried into the link domain
	always_ff @(posedge LINK_CLK) begin
		lrst_s1    <= RST_N;
		link_rst_n <= lrst_s1;
	end

	// Bus pins pass two flops; the third stage only feeds edge detection
	always_ff @(posedge LINK_CLK) begin
		scl_s1 <= SCL_I; // Link clock rate bounds the fastest bus rate
		scl_s2 <= scl_s1;
		scl_s3 <= scl_s2;
		sda_s1 <= SDA_I;
		sda_s2 <= sda_s1;
		sda_s3 <= sda_s2;
	end

	// All bit timing follows the bus clock edges, found by sampling the pins on LINK_CLK
	assign scl_rise = scl_s2 & ~scl_s3;
	assign scl_fall = ~scl_s2 & scl_s3;
	// Data moving while the clock is high is a condition, not a bit
	assign start_c  = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
	assign stop_c   = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

	assign byte_done = (state_q == ST_RX) && (cnt_q == BYTE_BITS) && scl_fall;
	assign addr_hit  = (shreg_q[7:1] == SLAVE_ADDR);
	// A full queue refuses the byte with a NACK rather than dropping it
	assign push      = byte_done && (kind_q == K_DATA);

	// Acknowledge decision for the byte just received
	always_comb begin
		unique case (kind_q)
			K_ADDR:  ack_d = addr_hit;
			K_INDEX: ack_d = 1'b1;
			K_DATA:  ack_d = fifo_w_ready;
			default: ack_d = 1'b0;
		endcase
	end

	// Session sequencer; START wins over everything but reset, even mid-byte
	always_ff @(posedge LINK_CLK) begin
		if (!link_rst_n) begin
			state_q <= ST_IDLE;
			kind_q  <= K_ADDR;
		end else if (start_c) begin
			state_q <= ST_RX;
			kind_q  <= K_ADDR;
		end else if (stop_c) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE, ST_IGNORE: begin
					state_q <= state_q;
				end
				ST_RX: begin
					if (byte_done) begin
						state_q <= ST_ACK;
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (!drive_q) begin
							state_q <= ST_IGNORE;
						end else if (kind_q == K_ADDR && rw_q == DIR_READ) begin
							state_q <= ST_TX;
						end else begin
							state_q <= ST_RX;
							kind_q  <= (kind_q == K_ADDR) ? K_INDEX : K_DATA;
						end
					end
				end
				ST_TX: begin
					if (scl_fall && cnt_q == BYTE_BITS) begin
						state_q <= ST_MACK;
					end
				end
				ST_MACK: begin
					if (scl_fall) begin
						state_q <= nak_q ? ST_IGNORE : ST_TX;
					end
				end
				// Unused codes fall back to a free bus
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Bit counter, cleared on each condition and at each byte boundary
	always_ff @(posedge LINK_CLK) begin
		if (!link_rst_n || start_c || stop_c) begin
			cnt_q <= 4'h0;
		end else if ((state_q == ST_RX || state_q == ST_TX) && scl_rise) begin
			cnt_q <= cnt_q + 4'h1;
		end else if (byte_done || (state_q == ST_TX && scl_fall && cnt_q == BYTE_BITS)) begin
			cnt_q <= 4'h0;
		end
	end

	// Receive shifter, MSB first, sampled on the rising clock
	always_ff @(posedge LINK_CLK) begin
		if (!link_rst_n) begin
			shreg_q <= DAT_RST;
		end else if (state_q == ST_RX && scl_rise) begin
			shreg_q <= {shreg_q[6:0], sda_s2};
		end
	end

	// Direction bit of the address byte
	always_ff @(posedge LINK_CLK) begin
		if (!link_rst_n) begin
			rw_q <= DIR_WRITE;
		end else if (byte_done && kind_q == K_ADDR) begin
			rw_q <= shreg_q[0];
		end
	end

	// Register index; kept across sessions so a later read sees it
	always_ff @(posedge LINK_CLK) begin
		if (!link_rst_n) begin
			index_q <= IDX_RST;
		end else if (byte_done && kind_q == K_INDEX) begin
			index_q <= shreg_q;
		end else if (push && fifo_w_ready) begin
			index_q <= index_q + 8'h01;
		end
	end

	// Master acknowledge sampled on the ninth rising clock of a read byte
	always_ff @(posedge LINK_CLK) begin
		if (!link_rst_n) begin
			nak_q <= 1'b1;
		end else if (state_q == ST_MACK && scl_rise) begin
			nak_q <= sda_s2;
		end
	end

	// Transmit shifter, reloaded from the fetched byte; index never moves
	always_ff @(posedge LINK_CLK) begin
		if (!link_rst_n) begin
			tx_q <= DAT_RST;
		end else if (scl_fall && ((state_q == ST_ACK && rw_q == DIR_READ) || state_q == ST_MACK)) begin
			tx_q <= rd_byte_q;
		end else if (state_q == ST_TX && scl_fall) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end
	end

	// Line driver: every change lands on a falling clock or a condition
	always_ff @(posedge LINK_CLK) begin
		if (!link_rst_n || start_c || stop_c) begin
			drive_q <= 1'b0;
		end else if (byte_done) begin
			drive_q <= ack_d;
		end else if (scl_fall) begin
			unique case (state_q)
				ST_ACK:  drive_q <= drive_q && rw_q == DIR_READ && kind_q == K_ADDR && !rd_byte_q[7];
				ST_TX:   drive_q <= (cnt_q != BYTE_BITS) && !tx_q[6];
				ST_MACK: drive_q <= !nak_q && !rd_byte_q[7];
				default: drive_q <= 1'b0;
			endcase
		end
	end

	// Read fetch request as a toggle, raised when a read address is accepted
	always_ff @(posedge LINK_CLK) begin
		if (!link_rst_n) begin
			rd_req_q <= 1'b0;
		end else if (byte_done && kind_q == K_ADDR && addr_hit && shreg_q[0] == DIR_READ) begin
			rd_req_q <= ~rd_req_q;
		end
	end

	// Fetched byte taken once the answer toggle has crossed back
	always_ff @(posedge LINK_CLK) begin
		rack_s1 <= rd_ack_q;
		rack_s2 <= rack_s1;
		rack_s3 <= rack_s2;
	end

	always_ff @(posedge LINK_CLK) begin
		if (!link_rst_n) begin
			rd_byte_q <= DAT_RST;
		end else if (rack_s2 != rack_s3) begin
			rd_byte_q <= rd_data_q;
		end
	end

	// Core side: request toggle synchroniser
	always_ff @(posedge CORE_CLK) begin
		rreq_s1 <= rd_req_q;
		rreq_s2 <= rreq_s1;
		rreq_s3 <= rreq_s2;
	end

	// Core side fetch; the link index is quiet while a read is pending
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			rd_index_q <= IDX_RST;
			rd_data_q  <= DAT_RST;
			fetch_q    <= 1'b0;
			rd_ack_q   <= 1'b0;
		end else if (rreq_s2 != rreq_s3) begin
			rd_index_q <= index_q;
			fetch_q    <= 1'b1;
		end else if (fetch_q) begin
			rd_data_q  <= RD_DATA;
			fetch_q    <= 1'b0;
			rd_ack_q   <= ~rd_ack_q;
		end
	end

	// Written words queue toward the core, which may stall them
	lmi_async_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_wq (
		.w_clk   (LINK_CLK),
		.w_rst_n (link_rst_n),
		.w_valid (push),
		.w_ready (fifo_w_ready),
		.w_data  ({index_q, shreg_q}),
		.r_clk   (CORE_CLK),
		.r_rst_n (RST_N),
		.r_valid (WR_VALID),
		.r_ready (WR_READY),
		.r_data  (fifo_r_data)
	);

	// Checks on the link-domain sequencer
	default clocking cb @(posedge LINK_CLK);
	endclocking
	default disable iff (!link_rst_n);

	sequence s_addr_done;
		byte_done && kind_q == K_ADDR;
	endsequence

	sequence s_ack_end;
		state_q == ST_ACK && scl_fall && !start_c && !stop_c;
	endsequence

	AST_START_RESTARTS: assert property (start_c |=> state_q == ST_RX && kind_q == K_ADDR && cnt_q == 4'h0)
		else $error("START did not restart address reception");

	AST_STOP_FREES: assert property (stop_c |=> state_q == ST_IDLE && !drive_q)
		else $error("STOP did not free the bus");

	AST_DRIVE_ON_LOW: assert property ($changed(drive_q) |-> $past(scl_fall || start_c || stop_c))
		else $error("data line changed outside a low clock phase");

	AST_ADDR_ACK: assert property ((s_addr_done and addr_hit) |=> state_q == ST_ACK && drive_q)
		else $error("own address was not acknowledged");

	AST_ADDR_IGNORE: assert property ((s_addr_done and !addr_hit) ##[1:60] s_ack_end |=> state_q == ST_IGNORE && !drive_q)
		else $error("foreign address was not ignored");

	AST_DIR_BIT: assert property (s_addr_done |=> rw_q == $past(shreg_q[0]))
		else $error("direction bit not captured");

	AST_BYTE_LEN: assert property (byte_done |-> $past(cnt_q) == BYTE_BITS)
		else $error("byte ended before eight bits");

	AST_INDEX_LOAD: assert property ((byte_done && kind_q == K_INDEX) |=> index_q == $past(shreg_q))
		else $error("register index not loaded");

	AST_INDEX_INC: assert property ((push && fifo_w_ready) |=> index_q == $past(index_q) + 8'h01)
		else $error("index did not advance after data");

	AST_READ_NO_INC: assert property ((state_q == ST_TX || state_q == ST_MACK) |=> $stable(index_q))
		else $error("index moved during a read");

	AST_MACK_RELEASE: assert property (state_q == ST_MACK |-> !drive_q)
		else $error("line held during master acknowledge");
endmodule

`default_nettype wire

//--- hdl/lmi_pkg.sv
`default_nettype none

package lmi_pkg;

	// Bus address the slave answers to, seven bits
	localparam logic [6:0] DEV_ADDR   = 7'h33;

	// Byte framing on the serial line
	localparam logic [3:0] BYTE_BITS  = 4'h8;

	// Register index and data widths
	localparam int         IDX_W      = 8;
	localparam int         DAT_W      = 8;
	localparam int         WORD_W     = IDX_W + DAT_W;

	// Write queue depth between the link and the core
	localparam int         FIFO_DEPTH = 8;

	// Reset values
	localparam logic [7:0] IDX_RST    = 8'h00;
	localparam logic [7:0] DAT_RST    = 8'h00;

	// Direction bit coding in the address byte
	localparam logic       DIR_WRITE  = 1'b0;
	localparam logic       DIR_READ   = 1'b1;

	// Link side sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK,
		ST_TX,
		ST_MACK,
		ST_IGNORE
	} lmi_state_t;

	// Role of the byte being received
	typedef enum logic [1:0] {
		K_ADDR,
		K_INDEX,
		K_DATA
	} lmi_kind_t;

endpackage

`default_nettype wire

//--- test/lmi_bus_master.sv
`default_nettype none

// Bus master model: opens and closes sessions, clocks bytes out and in
module lmi_bus_master #(
	parameter int T = 300
) (
	input  wire logic sda,
	output logic      scl,
	output logic      pull
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus: both lines released to the pull-up
	initial begin
		scl = 1'b1;
		pull = 1'b0;
	end

	// One clock pulse; data moves only in the low phase, sampled at the fall
	task automatic bit_io(input logic v, output logic s);
		#(T/4) pull = ~v;
		#(T*3/4) scl = 1'b1;
		#(T) s = sda;
		scl = 1'b0;
	endtask

	// Start or repeated start; the wait lets the slave drop its acknowledge first
	task automatic start();
		pull = 1'b0;
		#(T) scl = 1'b1;
		#(T) pull = 1'b1;
		#(T) scl = 1'b0;
	endtask

	// Stop: data rises while the clock is high
	task automatic stop();
		#(T/4) pull = 1'b1;
		#(T) scl = 1'b1;
		#(T) pull = 1'b0;
		#(T);
	endtask

	// Eight bits MSB first, then the acknowledge slot with data released
	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask

	// Read a byte, then acknowledge for more or leave data high on the last
	task automatic rd_byte(input logic more, output logic [7:0] b);
		logic s;
		for (int i = 0; i < 8; i++) begin
			bit_io(1'b1, s);
			b = {b[6:0], s};
		end
		bit_io(~more, s);
	endtask
endmodule

`default_nettype wire

//--- test/lmi_i2c_slave_tb.sv
`default_nettype none

// Self-checking bench for the serial slave port
module lmi_i2c_slave_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import lmi_pkg::*;

	logic        core_clk = 1'b0;
	logic        link_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wr_ready = 1'b1;
	logic        scl;
	logic        pull;
	logic        sda_o;
	logic        sda_oe_n;
	logic        wr_valid;
	logic [7:0]  wr_index;
	logic [7:0]  wr_data;
	logic [7:0]  rd_index;
	logic [7:0]  regs [256];
	logic [15:0] got [$];
	logic        a;
	logic [7:0]  d;
	int          fails = 0;
	int          checks_done = 0;
	int          oe_glitch = 0;
	// Open-drain wire with pull-up, pulled by either party
	wire logic   sda = ~(pull | (~sda_oe_n & ~sda_o));

	always #4 core_clk = ~core_clk;
	// Link clock with a phase unrelated to the core clock
	initial #5 forever #24 link_clk = ~link_clk;

	lmi_i2c_slave uut (
		.CORE_CLK (core_clk),
		.RST_N    (rst_n),
		.LINK_CLK (link_clk),
		.SCL_I    (scl),
		.SDA_I    (sda),
		.SDA_O    (sda_o),
		.SDA_OE_N (sda_oe_n),
		.WR_VALID (wr_valid),
		.WR_READY (wr_ready),
		.WR_INDEX (wr_index),
		.WR_DATA  (wr_data),
		.RD_INDEX (rd_index),
		.RD_DATA  (regs[rd_index])
	);

	lmi_bus_master master (
		.sda  (sda),
		.scl  (scl),
		.pull (pull)
	);

	// Core register file stores each word and logs it for comparison
	initial foreach (regs[i]) regs[i] <= 8'(i) ^ 8'h5A;
	always @(posedge core_clk) begin
		if (wr_valid === 1'b1 && wr_ready) begin
			regs[wr_index] <= wr_data;
			got.push_back({wr_index, wr_data});
		end
	end
	// A slave edge while the clock is high would read as a condition
	always @(sda_oe_n) if (scl === 1'b1 && rst_n) oe_glitch++;

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic send(input logic [7:0] b, input logic exp_ack);
		master.wr_byte(b, a);
		check("ack", {15'h0000, a}, {15'h0000, exp_ack});
	endtask

	// Bounded wait for the next word leaving the queue
	task automatic take(input logic [7:0] i, input logic [7:0] v);
		logic [15:0] w;
		for (int k = 0; k < 50 && got.size() == 0; k++) @(posedge core_clk);
		w = (got.size() > 0) ? got.pop_front() : 16'hXXXX;
		check("word", w, {i, v});
	endtask

	task automatic results();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic t_reset();
		check("oe_n", {15'h0000, sda_oe_n}, 16'h0001);
		check("sda_o", {15'h0000, sda_o}, 16'h0000);
		check("valid", {15'h0000, wr_valid}, 16'h0000);
		check("rd_index", {8'h00, rd_index}, {8'h00, IDX_RST});
		$display("test reset done");
	endtask

	// Burst across the index wrap
	task automatic t_write();
		master.start();
		send({DEV_ADDR, DIR_WRITE}, 1'b1);
		send(8'hFE, 1'b1);
		send(8'hA5, 1'b1);
		send(8'h3C, 1'b1);
		send(8'h81, 1'b1);
		master.stop();
		take(8'hFE, 8'hA5);
		take(8'hFF, 8'h3C);
		take(8'h00, 8'h81);
		$display("test write done");
	endtask

	// Repeated start in mid-write restarts address reception
	task automatic t_restart();
		master.start();
		send({DEV_ADDR, DIR_WRITE}, 1'b1);
		send(8'h40, 1'b1);
		send(8'h11, 1'b1);
		master.start();
		send({DEV_ADDR, DIR_WRITE}, 1'b1);
		send(8'h50, 1'b1);
		send(8'h22, 1'b1);
		master.stop();
		take(8'h40, 8'h11);
		take(8'h50, 8'h22);
		$display("test restart done");
	endtask

	// Index write, repeated start, two reads of the same register
	task automatic t_read();
		master.start();
		send({DEV_ADDR, DIR_WRITE}, 1'b1);
		send(8'hFE, 1'b1);
		master.start();
		send({DEV_ADDR, DIR_READ}, 1'b1);
		master.rd_byte(1'b1, d);
		check("rd_index", {8'h00, rd_index}, 16'h00FE);
		check("rd0", {8'h00, d}, 16'h00A5);
		master.rd_byte(1'b0, d);
		check("rd1", {8'h00, d}, 16'h00A5);
		master.stop();
		$display("test read done");
	endtask

	// Neighbouring addresses get no acknowledge and write nothing
	task automatic t_foreign();
		for (int k = 0; k < 2; k++) begin
			master.start();
			send({k ? DEV_ADDR + 7'h01 : DEV_ADDR - 7'h01, DIR_WRITE}, 1'b0);
			send(8'h10, 1'b0);
			master.stop();
		end
		repeat (50) @(posedge core_clk);
		check("words", 16'(got.size()), 16'h0000);
		$display("test foreign done");
	endtask

	// Core stalls: queue fills, the next data byte is refused, then drains in order
	task automatic t_full();
		@(posedge core_clk);
		#1 wr_ready = 1'b0;
		master.start();
		send({DEV_ADDR, DIR_WRITE}, 1'b1);
		send(8'h80, 1'b1);
		for (int k = 0; k < FIFO_DEPTH; k++) begin
			send(8'hC0 + 8'(k), 1'b1);
		end
		send(8'hEE, 1'b0);
		master.stop();
		check("valid", {15'h0000, wr_valid}, 16'h0001);
		@(posedge core_clk);
		#1 wr_ready = 1'b1;
		for (int k = 0; k < FIFO_DEPTH; k++) begin
			take(8'h80 + 8'(k), 8'hC0 + 8'(k));
		end
		repeat (20) @(posedge core_clk);
		check("words", 16'(got.size()), 16'h0000);
		check("glitch", 16'(oe_glitch), 16'h0000);
		$display("test full done");
	endtask

	// Reset spans enough link edges for the link domain to settle
	initial begin
		repeat (6) @(posedge link_clk);
		@(posedge core_clk);
		#1 rst_n = 1'b1;
		repeat (6) @(posedge link_clk);
		t_reset();
		t_write();
		t_restart();
		t_read();
		t_foreign();
		t_full();
		results();
	end

	// Watchdog well beyond the roughly 31 bytes of traffic
	initial begin
		#600000;
		fails++;
		$display("FAIL watchdog expected done seen timeout");
		results();
	end
endmodule

`default_nettype wire
